// [verilog/hbe_defines.svh]
/*
  Timing and encoding constants for the host bus emulation block.
  Assumes inclusion by bare name from files under verilog/.
*/
`ifndef HBE_DEFINES_SVH
`define HBE_DEFINES_SVH

// Command codes on the host command port
`define HBE_CMD_READ      3'h0
`define HBE_CMD_WRITE     3'h1
`define HBE_CMD_AUX_SET   3'h2
`define HBE_CMD_AUX_READ  3'h3
`define HBE_CMD_WAIT_HIGH 3'h4
`define HBE_CMD_WAIT_LOW  3'h5
`define HBE_CMD_IRQ_READ  3'h6

// Phase lengths in mclk cycles
`define HBE_ALE_CYCLES    3'h1
`define HBE_GAP_CYCLES    3'h1
`define HBE_STROBE_CYCLES 3'h2

// Aux mask/value bit positions
`define HBE_AUX0_BIT      0
`define HBE_AUX1_BIT      1
// Offset from a level bit to its drive enable bit
`define HBE_AUX_OE_OFS    4

`endif

// [verilog/hbe_pkg.sv]
/*
  Types shared by the host bus emulation block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package hbe_pkg;
  // Command encoding width
  typedef logic [2:0] hbe_cmd_t;
  // Bus cycle phases
  typedef enum logic [2:0] {
    HBE_IDLE,
    HBE_WAIT_LVL,
    HBE_ALE,
    HBE_GAP,
    HBE_STROBE,
    HBE_HOLD
  } hbe_state_t;
endpackage : hbe_pkg
`default_nettype wire

// [verilog/hbe_phase_if.sv]
/*
  Interface carrying the phase counter handshake between the sequencer
  and its counter. Assumes a single mclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface hbe_phase_if;
  logic       load;   // Restart counter
  logic [2:0] length; // Cycles to count
  logic       hold;   // Freeze while peripheral not ready
  logic       done;   // Count has expired
  modport seq (output load, output length, output hold, input done);
  modport cnt (input load, input length, input hold, output done);
endinterface : hbe_phase_if
`default_nettype wire

// [verilog/hbe_phase_counter.sv]
/*
  Phase length counter for the bus sequencer.
  Assumes mclk and nrst as for the top module.
*/
`timescale 1ns/100ps
`default_nettype none
`include "hbe_defines.svh"
module hbe_phase_counter
(
  input  wire logic  mclk,
  input  wire logic  nrst,
  hbe_phase_if.cnt   ph
);
  import hbe_pkg::*;

  logic [2:0] count;      // Cycles left
  logic [2:0] next_count;

  // Next count: load, hold or decrement
  always_comb
  begin
    next_count = count;
    if (ph.load)
    begin
      next_count = ph.length;
    end
    else if (!ph.hold && count != 3'h0)
    begin
      next_count = count - 3'h1;
    end
  end

  // Register count
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      count <= 3'h0;
    end
    else
    begin
      count <= next_count;
    end
  end

  // Expired when one remains and not held; load left out to avoid a loop
  assign ph.done = (count == 3'h1) && !ph.hold;
endmodule : hbe_phase_counter
`default_nettype wire

// [verilog/hbe_host_bus.sv]
/*
  Host bus emulation master: multiplexed address/data bus, high address,
  select, latch pulse, strobes, ready stretch, clock out and aux pins.
  Assumes a host command port synchronous to mclk and a peripheral
  whose inputs are synchronous to mclk.
*/
// Overview of operation
// - Both channels form one host bus master
// - Low address then data share one bus
// - High address byte on dedicated outputs
// - Select low for whole read or write
// - Latch pulse while low address driven
// - Read strobe low marks read cycle
// - Write data set up before, held after strobe
// - Ready low stretches the current access
// - Clock output toggles every mclk cycle, at half the mclk rate
// - Two aux pins set, cleared, read
// - Commands wait for aux pin high or low
// - Wait for interrupt level then read
// - Wait pin kept as input while waiting
`timescale 1ns/100ps
`default_nettype none
`include "hbe_defines.svh"
module hbe_host_bus
(
  input  wire logic           mclk,
  input  wire logic           nrst,
  input  wire logic           cmd_valid,
  input  wire hbe_pkg::hbe_cmd_t cmd_code,
  input  wire logic [15:0]    cmd_addr,
  input  wire logic [7:0]     cmd_data,
  output logic                cmd_ready,
  output logic                rsp_valid,
  output logic [7:0]          rsp_data,
  input  wire logic [7:0]     addr_data_low_bus_in,
  output logic [7:0]          addr_data_low_bus_out,
  output logic                addr_data_low_bus_oe_n,
  output logic [7:0]          addr_high,
  output logic                sel_n,
  output logic                addr_latch,
  output logic                rd_n,
  output logic                wr_n,
  input  wire logic           cycle_ready_in,
  output logic                bus_master_clock_out,
  input  wire logic           aux_pin_zero_in,
  output logic                aux_pin_zero_out,
  output logic                aux_pin_zero_oe_n,
  input  wire logic           aux_pin_wait_irq_in,
  output logic                aux_pin_wait_irq_out,
  output logic                aux_pin_wait_irq_oe_n
);
  import hbe_pkg::*;

  // ************************************************************
  // Sequencer state
  // ************************************************************
  hbe_state_t state, next_state;         // Bus phase
  logic       is_write, next_is_write;   // Access direction
  logic       wait_lvl, next_wait_lvl;   // Awaited aux level
  logic       irq_rd, next_irq_rd;       // Read follows the wait
  logic [15:0] addr, next_addr;          // Latched address
  logic [7:0] wdata, next_wdata;         // Write data
  logic       clk_div, next_clk_div;     // Clock out divider
  logic [7:0] next_rsp_data;
  logic [7:0] next_ad_out;
  logic       next_ad_oe_n, next_sel_n, next_ale, next_rd_n, next_wr_n;
  logic       next_cmd_ready, next_rsp_valid;
  logic       next_a0_out, next_a0_oe_n, next_a1_out, next_a1_oe_n;

  hbe_phase_if ph ();

  hbe_phase_counter u_cnt
  (
    .mclk (mclk),
    .nrst (nrst),
    .ph   (ph)
  );

  // Decode of access commands
  function automatic logic is_bus_cmd(input hbe_cmd_t c);
    is_bus_cmd = (c == `HBE_CMD_READ) || (c == `HBE_CMD_WRITE);
  endfunction : is_bus_cmd

  // ************************************************************
  // Next state computation
  // ************************************************************
  always_comb
  begin
    next_state     = state;
    next_is_write  = is_write;
    next_wait_lvl  = wait_lvl;
    next_irq_rd    = irq_rd;
    next_addr      = addr;
    next_wdata     = wdata;
    next_rsp_data  = rsp_data;
    next_ad_out    = addr_data_low_bus_out;
    next_ad_oe_n   = addr_data_low_bus_oe_n;
    next_sel_n     = sel_n;
    next_ale       = 1'b0;
    next_rd_n      = rd_n;
    next_wr_n      = wr_n;
    next_rsp_valid = 1'b0;
    next_cmd_ready = 1'b0;
    next_a0_out    = aux_pin_zero_out;
    next_a0_oe_n   = aux_pin_zero_oe_n;
    next_a1_out    = aux_pin_wait_irq_out;
    next_a1_oe_n   = aux_pin_wait_irq_oe_n;
    next_clk_div   = ~clk_div;
    ph.load        = 1'b0;
    ph.length      = `HBE_ALE_CYCLES;
    ph.hold        = 1'b0;
    unique case (state)
      HBE_IDLE:
      begin
        next_cmd_ready = 1'b1;
        if (cmd_valid && cmd_ready)
        begin
          next_cmd_ready = 1'b0;
          next_addr      = cmd_addr;
          next_wdata     = cmd_data;
          next_is_write  = (cmd_code == `HBE_CMD_WRITE);
          next_irq_rd    = 1'b0;
          if (is_bus_cmd(cmd_code))
          begin
            // Start access: low address on bus, select asserted
            next_state   = HBE_ALE;
            next_ad_out  = cmd_addr[7:0];
            next_ad_oe_n = 1'b0;
            next_sel_n   = 1'b0;
            next_ale     = 1'b1;
            ph.load      = 1'b1;
            ph.length    = `HBE_ALE_CYCLES;
          end
          else if (cmd_code == `HBE_CMD_AUX_SET)
          begin
            // Data bits 1:0 value, bits 5:4 output enables
            next_a0_out  = cmd_data[`HBE_AUX0_BIT];
            next_a1_out  = cmd_data[`HBE_AUX1_BIT];
            next_a0_oe_n = ~cmd_data[`HBE_AUX0_BIT + `HBE_AUX_OE_OFS];
            next_a1_oe_n = ~cmd_data[`HBE_AUX1_BIT + `HBE_AUX_OE_OFS];
            next_state   = HBE_HOLD;
          end
          else if (cmd_code == `HBE_CMD_AUX_READ)
          begin
            next_rsp_data  = {6'h00, aux_pin_wait_irq_in, aux_pin_zero_in};
            next_rsp_valid = 1'b1;
            next_state     = HBE_HOLD;
          end
          else
          begin
            // Wait commands; IRQ read waits for high then reads
            next_wait_lvl = (cmd_code != `HBE_CMD_WAIT_LOW);
            next_irq_rd   = (cmd_code == `HBE_CMD_IRQ_READ);
            next_a1_oe_n  = 1'b1;
            next_state    = HBE_WAIT_LVL;
          end
        end
      end
      HBE_WAIT_LVL:
      begin
        next_a1_oe_n = 1'b1;
        if (aux_pin_wait_irq_in == wait_lvl)
        begin
          if (irq_rd)
          begin
            // Queued read starts once interrupt level seen
            next_is_write = 1'b0;
            next_state    = HBE_ALE;
            next_ad_out   = addr[7:0];
            next_ad_oe_n  = 1'b0;
            next_sel_n    = 1'b0;
            next_ale      = 1'b1;
            ph.load       = 1'b1;
            ph.length     = `HBE_ALE_CYCLES;
          end
          else
          begin
            next_state = HBE_HOLD;
          end
        end
      end
      HBE_ALE:
      begin
        if (ph.done)
        begin
          // Latch pulse over before any strobe
          next_state   = HBE_GAP;
          next_ad_out  = is_write ? wdata : 8'h00;
          next_ad_oe_n = !is_write;
          ph.load      = 1'b1;
          ph.length    = `HBE_GAP_CYCLES;
        end
      end
      HBE_GAP:
      begin
        if (ph.done)
        begin
          // Exactly one strobe falls
          next_state = HBE_STROBE;
          next_rd_n  = is_write;
          next_wr_n  = !is_write;
          ph.load    = 1'b1;
          ph.length  = `HBE_STROBE_CYCLES;
        end
      end
      HBE_STROBE:
      begin
        ph.hold = !cycle_ready_in;
        if (ph.done)
        begin
          next_rd_n = 1'b1;
          next_wr_n = 1'b1;
          if (!is_write)
          begin
            // Sample as read strobe rises
            next_rsp_data  = addr_data_low_bus_in;
            next_rsp_valid = 1'b1;
          end
          next_state = HBE_HOLD;
        end
      end
      HBE_HOLD:
      begin
        // Data held one cycle past write strobe, then release
        next_ad_oe_n = 1'b1;
        next_sel_n   = 1'b1;
        next_state   = HBE_IDLE;
      end
      default:
      begin
        next_state = HBE_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state                  <= HBE_IDLE;
      is_write               <= 1'b0;
      wait_lvl               <= 1'b0;
      irq_rd                 <= 1'b0;
      addr                   <= 16'h0000;
      wdata                  <= 8'h00;
      clk_div                <= 1'b0;
      rsp_data               <= 8'h00;
      rsp_valid              <= 1'b0;
      cmd_ready              <= 1'b0;
      addr_data_low_bus_out  <= 8'h00;
      addr_data_low_bus_oe_n <= 1'b1;
      addr_high              <= 8'h00;
      sel_n                  <= 1'b1;
      addr_latch             <= 1'b0;
      rd_n                   <= 1'b1;
      wr_n                   <= 1'b1;
      bus_master_clock_out   <= 1'b0;
      aux_pin_zero_out       <= 1'b0;
      aux_pin_zero_oe_n      <= 1'b1;
      aux_pin_wait_irq_out   <= 1'b0;
      aux_pin_wait_irq_oe_n  <= 1'b1;
    end
    else
    begin
      state                  <= next_state;
      is_write               <= next_is_write;
      wait_lvl               <= next_wait_lvl;
      irq_rd                 <= next_irq_rd;
      addr                   <= next_addr;
      wdata                  <= next_wdata;
      clk_div                <= next_clk_div;
      rsp_data               <= next_rsp_data;
      rsp_valid              <= next_rsp_valid;
      cmd_ready              <= next_cmd_ready;
      addr_data_low_bus_out  <= next_ad_out;
      addr_data_low_bus_oe_n <= next_ad_oe_n;
      addr_high              <= next_addr[15:8];
      sel_n                  <= next_sel_n;
      addr_latch             <= next_ale;
      rd_n                   <= next_rd_n;
      wr_n                   <= next_wr_n;
      bus_master_clock_out   <= next_clk_div;
      aux_pin_zero_out       <= next_a0_out;
      aux_pin_zero_oe_n      <= next_a0_oe_n;
      aux_pin_wait_irq_out   <= next_a1_out;
      aux_pin_wait_irq_oe_n  <= next_a1_oe_n;
    end
  end
endmodule : hbe_host_bus
`default_nettype wire

// [verification/hbe_periph_model.sv]
/* Peripheral model for the multiplexed bus: latches the low address,
   answers reads, stores writes, stalls when asked.
   Assumes bus signals launched on mclk rising edges. */
`timescale 1ns/100ps
`default_nettype none
module hbe_periph_model
(
  input  wire logic       mclk,
  input  wire logic [7:0] bus,
  input  wire logic       addr_latch,
  input  wire logic       sel_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [3:0] stall,
  output logic      [7:0] drive,
  output logic            ready
);
  // ****************
  // Storage and bus
  // ****************
  logic [7:0] mem [256]; // Byte store by low address
  logic [7:0] lat = 8'h00; // Latched low address
  logic [7:0] junk = 8'h00; // Released-bus pattern
  logic [3:0] cnt = 4'h0; // Stall cycles spent
  logic       strobe; // Either strobe low
  logic       stalled = 1'b0; // Stretch in progress
  assign strobe = !(rd_n && wr_n);
  assign ready = !stalled;
  // Drive read data only while selected with read strobe low; else a changing pattern
  assign drive = (!sel_n && !rd_n) ? mem[lat] : junk;
  // Latch, write capture and ready stretch
  always @(posedge mclk)
  begin
    junk <= ~drive;
    if (addr_latch) lat <= bus;
    if (!sel_n && !wr_n) mem[lat] <= bus;
    if (sel_n) cnt <= 4'h0;
    else if (strobe && cnt < stall) cnt <= cnt + 4'h1;
    stalled <= !sel_n && strobe && cnt < stall;
  end
endmodule : hbe_periph_model
`default_nettype wire

// [verification/hbe_host_bus_assertions.sv]
/* Timing checks on the host bus master ports.
   Assumes binding into hbe_host_bus, single mclk domain. */
`timescale 1ns/100ps
`default_nettype none
`include "hbe_defines.svh"
module hbe_host_bus_checker
(
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              cmd_valid,
  input wire hbe_pkg::hbe_cmd_t cmd_code,
  input wire logic [15:0]       cmd_addr,
  input wire logic              cmd_ready,
  input wire logic              rsp_valid,
  input wire logic [7:0]        rsp_data,
  input wire logic [7:0]        addr_data_low_bus_in,
  input wire logic [7:0]        addr_data_low_bus_out,
  input wire logic              addr_data_low_bus_oe_n,
  input wire logic [7:0]        addr_high,
  input wire logic              sel_n,
  input wire logic              addr_latch,
  input wire logic              rd_n,
  input wire logic              wr_n,
  input wire logic              cycle_ready_in,
  input wire logic              bus_master_clock_out
);
  import hbe_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence take_read;
    cmd_valid && cmd_ready && cmd_code == `HBE_CMD_READ;
  endsequence
  sequence strobe_fall;
    $fell(rd_n) || $fell(wr_n);
  endsequence
  addr_phase_a: assert property ($rose(addr_latch) |-> !addr_data_low_bus_oe_n
    && addr_data_low_bus_out == $past(cmd_addr[7:0]) && addr_high == $past(cmd_addr[15:8]))
    else $error("address phase wrong");
  latch_sel_a: assert property (addr_latch |-> !sel_n) else $error("latch without select");
  strobe_sel_a: assert property (!(rd_n && wr_n) |-> !sel_n)
    else $error("strobe without select");
  one_strobe_a: assert property (!(!rd_n && !wr_n)) else $error("both strobes low");
  read_release_a: assert property (!rd_n |-> addr_data_low_bus_oe_n)
    else $error("bus driven during read");
  latch_first_a: assert property (strobe_fall |-> !addr_latch && !$past(addr_latch))
    else $error("strobe overlaps latch");
  write_setup_a: assert property ($fell(wr_n) |-> !$past(addr_data_low_bus_oe_n)
    && $stable(addr_data_low_bus_out)) else $error("write data not set up");
  write_hold_a: assert property ($rose(wr_n) |-> !addr_data_low_bus_oe_n
    && $stable(addr_data_low_bus_out)) else $error("write data not held");
  ready_stretch_a: assert property (!(rd_n && wr_n) && !cycle_ready_in |=>
    $stable(rd_n) && $stable(wr_n)) else $error("strobe ended while not ready");
  read_capture_a: assert property ($rose(rd_n) |-> rsp_valid
    && rsp_data == $past(addr_data_low_bus_in)) else $error("read data not captured");
  read_answer_a: assert property (take_read |-> ##[5:40] rsp_valid)
    else $error("read answer missing");
  clock_out_a: assert property ($past(nrst) |-> bus_master_clock_out !=
    $past(bus_master_clock_out)) else $error("clock output stalled");
endmodule : hbe_host_bus_checker
bind hbe_host_bus hbe_host_bus_checker chk (.mclk, .nrst, .cmd_valid, .cmd_code, .cmd_addr,
  .cmd_ready, .rsp_valid, .rsp_data, .addr_data_low_bus_in, .addr_data_low_bus_out,
  .addr_data_low_bus_oe_n, .addr_high, .sel_n, .addr_latch, .rd_n, .wr_n, .cycle_ready_in,
  .bus_master_clock_out);
`default_nettype wire

// [verification/test_mcu_host_bus_emulation.sv]
/* Bench for the host bus master: table of bus cycles, then aux, wait
   and reset cases. Assumes the peripheral model and the checker. */
`timescale 1ns/100ps
`default_nettype none
`include "hbe_defines.svh"
module test_mcu_host_bus_emulation;
  import hbe_pkg::*;
  // ****************
  // Signals
  // ****************
  typedef struct {hbe_cmd_t c; logic [15:0] a; logic [7:0] d; logic [3:0] s; logic [7:0] e;}
    hbe_row_t;
  logic mclk, nrst, cmd_valid, cmd_ready, rsp_valid, oe_n, addr_latch, sel_n, rd_n, wr_n;
  logic rdy, clk_out, a0_out, a0_oe_n, a1_out, a1_oe_n, a0_lvl, a1_lvl;
  hbe_cmd_t    cmd_code;
  logic [15:0] cmd_addr;
  logic [7:0]  cmd_data, rsp_data, ad_out, ad_hi, m_drive, got;
  logic [3:0]  stall;
  wire logic [7:0] ad_bus = oe_n ? m_drive : ad_out; // Resolved bus
  wire logic       a0_w = a0_oe_n ? a0_lvl : a0_out;
  wire logic       a1_w = a1_oe_n ? a1_lvl : a1_out;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  // Writes then reads: boundary addresses, varied stalls
  hbe_row_t rows[6] = '{'{`HBE_CMD_WRITE, 16'h0000, 8'h3c, 4'h0, 8'h00},
    '{`HBE_CMD_WRITE, 16'hffff, 8'hc3, 4'h2, 8'h00}, '{`HBE_CMD_WRITE, 16'h12a5, 8'h5a, 4'h1, 8'h00},
    '{`HBE_CMD_READ, 16'h0000, 8'h00, 4'h3, 8'h3c}, '{`HBE_CMD_READ, 16'hffff, 8'h00, 4'h0, 8'hc3},
    '{`HBE_CMD_READ, 16'h12a5, 8'h00, 4'h1, 8'h5a}};
  hbe_host_bus dut (.mclk, .nrst, .cmd_valid, .cmd_code, .cmd_addr, .cmd_data, .cmd_ready,
    .rsp_valid, .rsp_data, .addr_data_low_bus_in(ad_bus), .addr_data_low_bus_out(ad_out),
    .addr_data_low_bus_oe_n(oe_n), .addr_high(ad_hi), .sel_n, .addr_latch, .rd_n, .wr_n,
    .cycle_ready_in(rdy), .bus_master_clock_out(clk_out), .aux_pin_zero_in(a0_w),
    .aux_pin_zero_out(a0_out), .aux_pin_zero_oe_n(a0_oe_n), .aux_pin_wait_irq_in(a1_w),
    .aux_pin_wait_irq_out(a1_out), .aux_pin_wait_irq_oe_n(a1_oe_n));
  hbe_periph_model peri (.mclk, .bus(ad_bus), .addr_latch, .sel_n, .rd_n, .wr_n, .stall,
    .drive(m_drive), .ready(rdy));
  // ****************
  // Tasks
  // ****************
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // Offer one command, wait for its answer and for idle again
  task run(input hbe_cmd_t c, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    while (cmd_ready !== 1'b1 && n < 60)
    begin
      n++;
      @(posedge mclk);
    end
    cmd_valid <= 1'b0;
    if (c == `HBE_CMD_READ || c == `HBE_CMD_AUX_READ || c == `HBE_CMD_IRQ_READ)
    begin
      @(posedge mclk);
      while (rsp_valid !== 1'b1 && n < 60)
      begin
        n++;
        @(posedge mclk);
      end
    end
    got = rsp_data;
    @(posedge mclk);
    while (cmd_ready !== 1'b1 && n < 60)
    begin
      n++;
      @(posedge mclk);
    end
    // A command that never finishes counts as a mismatch
    chk({7'h00, n < 60}, 8'h01);
  endtask : run
  // Hold the wait pin level a while, then change it
  task lvl_late(input logic v);
    repeat (8) @(posedge mclk);
    chk({cmd_ready, a1_oe_n, sel_n}, 8'h03);
    a1_lvl <= v;
  endtask : lvl_late
  // ****************
  // Sequence
  // ****************
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Cycle ceiling cuts a hang short
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial
  begin
    {nrst, cmd_valid, a0_lvl, a1_lvl} = 4'h0;
    {cmd_code, cmd_addr, cmd_data, stall} = '0;
    repeat (6) @(posedge mclk);
    chk({sel_n, rd_n, wr_n, oe_n, addr_latch, cmd_ready}, 8'h3c);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      stall <= rows[i].s;
      run(rows[i].c, rows[i].a, rows[i].d);
      if (rows[i].c == `HBE_CMD_READ) chk(got, rows[i].e);
    end
    run(`HBE_CMD_AUX_SET, 16'h0000, 8'h11);
    chk({a0_oe_n, a0_out, a1_oe_n}, 8'h03);
    run(`HBE_CMD_AUX_READ, 16'h0000, 8'h00);
    chk(got[1:0], 8'h01);
    run(`HBE_CMD_AUX_SET, 16'h0000, 8'h10);
    a1_lvl <= 1'b1;
    run(`HBE_CMD_AUX_READ, 16'h0000, 8'h00);
    chk(got[1:0], 8'h02);
    a1_lvl <= 1'b0;
    // Drive the wait pin high against a low pull, release the other pin
    run(`HBE_CMD_AUX_SET, 16'h0000, 8'h23);
    chk({a1_oe_n, a1_out, a0_oe_n}, 8'h03);
    run(`HBE_CMD_AUX_READ, 16'h0000, 8'h00);
    chk(got[1:0], 8'h02);
    fork run(`HBE_CMD_WAIT_HIGH, 16'h0000, 8'h00); lvl_late(1'b1); join
    fork run(`HBE_CMD_WAIT_LOW, 16'h0000, 8'h00); lvl_late(1'b0); join
    fork run(`HBE_CMD_IRQ_READ, 16'h12a5, 8'h00); lvl_late(1'b1); join
    chk(got, 8'h5a);
    // Reset strikes while the read strobe is low; bus must idle, then work
    cmd_code <= `HBE_CMD_READ;
    cmd_addr <= 16'h0000;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    chk({sel_n, rd_n, addr_latch}, 8'h06);
    nrst <= 1'b1;
    run(`HBE_CMD_READ, 16'h0000, 8'h00);
    chk(got, 8'h3c);
    tally_and_finish;
  end
endmodule : test_mcu_host_bus_emulation
`default_nettype wire
